/* logic/swfpc_pkg.sv */
// Constants, register map and types for the dual-channel switch control.
// Assumes a 100 MHz system clock and a 32-bit APB register port.
//
// Notes on behaviour
// - Fault status pin goes low live while any fault is present.
// - Fault sets a sticky bit that survives until its register is read.
// - Faults switch the channel off; openload, clock fail, short-to-supply do not.
// - Short, openload off/on enables default off; clock fail, overvoltage on.
// - Fault mode when woken and fault term high, whatever fail-safe says.
// - Read clears a fault bit only once cause is gone and unlatched.
// - Fault in fail-safe keeps registers reset and locked; pins steer.
// - Leaving fault back to fail-safe keeps counter, latches, reset registers.
// - Latchable fault: off, status low, bit set, held until retry turn-on.
// - Auto-retry turns channel on again; bit stays until read.
// - Cause still present after last retry latches the channel off.
// - Delatch clears latched bits; status releases once both delatched.
// - Delatch by fault-control high-low-high or retry counter reset.
// - Fault-control is input-active and direct enabled, or on bit.
// - Fail-safe entry from fault mode delatches and resets registers.
// - New faults in fail-safe keep counter and latches untouched.
// - Each channel has its own modulator; clock select picks int/ext.
// - Period is 256 clocks internal, 256 or 512 external.
// - On bit low means off; duty n gives (n+1)/256, all ones full on.
// - Delay code adds 32 modulator clock periods per step; zero none.
// - Wake is reset pin or input-active; fault term ORs latchable and OV.
// - Input-active drops after 250 ms of no input activity.

package swfpc_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned IN_TIMEOUT_MS = 250;
	localparam int unsigned IN_TIMEOUT_CYC = IN_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int unsigned RETRY_CYC_DEF = 1000;
	localparam int unsigned INT_DIV_DEF = 16;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 8;
	typedef logic [ADDR_W-1:0] swfpc_addr_t;
	localparam swfpc_addr_t A_GCFG = 8'h00;
	localparam swfpc_addr_t A_GSTAT = 8'h04;
	localparam swfpc_addr_t A_DUTY0 = 8'h08;
	localparam swfpc_addr_t A_DUTY1 = 8'h0C;
	localparam swfpc_addr_t A_CCFG0 = 8'h10;
	localparam swfpc_addr_t A_CCFG1 = 8'h14;
	localparam swfpc_addr_t A_CUR0 = 8'h18;
	localparam swfpc_addr_t A_CUR1 = 8'h1C;
	localparam swfpc_addr_t A_FLT0 = 8'h20;
	localparam swfpc_addr_t A_FLT1 = 8'h24;
	localparam swfpc_addr_t A_RETRY = 8'h28;

	// Global config fields
	localparam int G_OS_EN = 0;
	localparam int G_OLOFF_EN = 1;
	localparam int G_OLON_EN = 2;
	localparam int G_CLKF_EN = 3;
	localparam int G_OV_EN = 5;
	localparam int G_PWM_EN0 = 7;
	localparam int GCFG_W = 9;
	localparam logic [GCFG_W-1:0] GCFG_RST = 9'h028;
	localparam logic [GCFG_W-1:0] GCFG_MASK = 9'h1AF;

	// Duty register
	localparam int DUTY_W = 8;
	localparam int ON_BIT = 8;
	typedef logic [DUTY_W-1:0] swfpc_duty_t;
	localparam logic [ON_BIT:0] DUTY_RST = 9'h000;

	// Channel config: delay and direct-input disable
	localparam int DELAY_W = 3;
	localparam int DIR_DIS_BIT = 3;
	typedef logic [DELAY_W-1:0] swfpc_delay_t;
	localparam logic [DIR_DIS_BIT:0] CCFG_RST = 4'h0;
	localparam int DELAY_SHIFT = 5;

	// Current config: retry limit/enable, clock select, prescaler
	localparam int R_LIM_W = 4;
	localparam int R_EN_BIT = 4;
	localparam int CLK_INT_BIT = 6;
	localparam int PRESC_BIT = 7;
	localparam logic [7:0] CUR_RST = 8'h40;
	localparam logic [7:0] CUR_MASK = 8'hDF;

	// Channel fault bits
	localparam int F_OC = 0;
	localparam int F_SC = 1;
	localparam int F_OT = 2;
	localparam int F_OS = 3;
	localparam int F_OLON = 4;
	localparam int F_OLOFF = 5;
	localparam int F_LATCH = 6;
	localparam int FLT_W = 6;
	localparam logic [FLT_W-1:0] FLT_LATCHABLE = 6'h07;

	// Global status bits
	localparam int S_UV = 0;
	localparam int S_OV = 1;
	localparam int S_CLKF = 2;
	localparam int S_FMODE = 4;
	localparam int S_FSAFE = 5;
	localparam int S_FSTAT = 6;

	localparam int PWM_CNT_W = 8;

	// ----------------------------------------------------------------
	// Operating modes, Gray along sleep-normal-fault-fault/failsafe
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		M_SLEEP = 3'h0,
		M_NORMAL = 3'h1,
		M_FAULT = 3'h3,
		M_FLT_FS = 3'h2,
		M_FSAFE = 3'h6
	} swfpc_mode_t;

endpackage

/* logic/swfpc_pwm_if.sv */
// Carrier between the control top and one channel modulator.
// Assumes the control side drives every setting on the system clock.
`timescale 1ns/1ns
`default_nettype none

interface swfpc_pwm_if;
	logic enable;
	logic clk_int;
	logic prescale;
	logic on;
	logic ext_tick;
	logic int_tick;
	swfpc_pkg::swfpc_duty_t duty;
	swfpc_pkg::swfpc_delay_t delay;
	logic pwm_out;

	modport ctrl(output enable, output clk_int, output prescale, output on,
		output ext_tick, output int_tick, output duty, output delay,
		input pwm_out);
	modport pwm(input enable, input clk_int, input prescale, input on,
		input ext_tick, input int_tick, input duty, input delay,
		output pwm_out);
endinterface

`default_nettype wire

/* logic/swfpc_pwm.sv */
// One channel modulator: tick select, switch-on delay, 8-bit duty.
// Assumes ticks are single-cycle pulses on the system clock.
`timescale 1ns/1ns
`default_nettype none

module swfpc_pwm (
	input wire logic clock,
	input wire logic rst_b,
	swfpc_pwm_if.pwm bus
);
	import swfpc_pkg::*;

	logic half_q;
	logic en_q;
	logic tick;
	logic run;
	logic [DELAY_W+DELAY_SHIFT-1:0] wait_q;
	logic [PWM_CNT_W-1:0] cnt_q;
	logic out_q;

	// ----------------------------------------------------------------
	// Clock select and prescaler
	// ----------------------------------------------------------------
	// Prescaler only applies to the external clock
	assign tick = bus.clk_int ? bus.int_tick :
		(bus.ext_tick & (~bus.prescale | half_q));

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			half_q <= 1'b0;
		else if (!bus.enable)
			half_q <= 1'b0;
		else if (!bus.clk_int && bus.ext_tick)
			half_q <= ~half_q;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			en_q <= 1'b0;
		else
			en_q <= bus.enable;
	end

	// ----------------------------------------------------------------
	// Switch-on delay, loaded when the modulator is enabled
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			wait_q <= '0;
		else if (bus.enable && !en_q)
			wait_q <= {bus.delay, {DELAY_SHIFT{1'b0}}};
		else if (tick && wait_q != '0)
			wait_q <= wait_q - 1'b1;
	end

	assign run = en_q & bus.enable & (wait_q == '0);

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			cnt_q <= '0;
		else if (!run)
			cnt_q <= '0;
		else if (tick)
			cnt_q <= cnt_q + 1'b1;
	end

	// ----------------------------------------------------------------
	// Output: count <= n is high n+1 slots of 256
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			out_q <= 1'b0;
		else if (!bus.enable)
			out_q <= bus.on;
		else if (!run)
			out_q <= 1'b0;
		else
			out_q <= bus.on & (cnt_q <= bus.duty);
	end

	assign bus.pwm_out = out_q;
endmodule

`default_nettype wire

/* logic/swfpc_top.sv */
// Fault supervision, retry/latch, operating mode and APB registers
// for two high-side channels. Fault detector inputs come from logic
// already on this clock; input pins and external clock are synchronised.
`timescale 1ns/1ns
`default_nettype none

module swfpc_top #(
	parameter int unsigned IN_TIMEOUT = swfpc_pkg::IN_TIMEOUT_CYC,
	parameter int unsigned RETRY_CYC = swfpc_pkg::RETRY_CYC_DEF,
	parameter int unsigned INT_DIV = swfpc_pkg::INT_DIV_DEF
) (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire swfpc_pkg::swfpc_addr_t paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] in_pin,
	input wire logic reset_pin_n,
	input wire logic ext_clock_pin,
	input wire logic [1:0] overcurrent_fault,
	input wire logic [1:0] severe_short_fault,
	input wire logic [1:0] overtemp_fault,
	input wire logic [1:0] short_supply_fault,
	input wire logic [1:0] openload_on_fault,
	input wire logic [1:0] openload_off_fault,
	input wire logic undervoltage_fault,
	input wire logic overvoltage_fault,
	input wire logic ext_clock_fail,
	input wire logic failsafe_req,
	output logic [1:0] hs_on,
	output logic fault_status_n,
	output swfpc_pkg::swfpc_mode_t mode
);
	import swfpc_pkg::*;

	localparam int TMR_W = $clog2(IN_TIMEOUT + 1);
	localparam int RTY_W = $clog2(RETRY_CYC + 1);
	localparam int DIV_W = $clog2(INT_DIV + 1);

	logic [1:0] in_s1_q, in_s2_q;
	logic rp_s1_q, rp_s2_q;
	logic ext_s1_q, ext_s2_q, ext_s3_q;
	logic [1:0] in_on_q;
	logic [TMR_W-1:0] in_tmr_q [2];
	logic [DIV_W-1:0] div_q;
	logic int_tick;

	logic [GCFG_W-1:0] gcfg_q;
	logic [ON_BIT:0] duty_q [2];
	logic [DIR_DIS_BIT:0] ccfg_q [2];
	logic [7:0] cur_q [2];
	logic [FLT_W-1:0] flt_q [2];
	logic [S_CLKF:0] gstat_q;
	logic [1:0] latched_q, tripped_q, seen_on_q;
	logic [1:0] fc_prev_q, fc_arm_q;
	logic [R_LIM_W-1:0] rcnt_q [2];
	logic [RTY_W-1:0] rtmr_q [2];
	logic [31:0] prdata_q;
	logic pslverr_q;
	logic [1:0] hs_on_q;
	logic fstat_n_q;

	swfpc_mode_t mode_q, mode_d;
	logic wake, fault_term, fs_now, fs_entry, acc, wr, rd, clk_fail_act;
	logic [31:0] rd_data;
	logic rd_ok;
	logic [1:0] pwm_out, ch_fault;

	function automatic logic hit(input swfpc_addr_t a, input swfpc_addr_t r);
		return a == r;
	endfunction

	// ----------------------------------------------------------------
	// Pin synchronisers and internal tick divider
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			in_s1_q <= 2'h0;
			in_s2_q <= 2'h0;
			rp_s1_q <= 1'b0;
			rp_s2_q <= 1'b0;
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			in_s1_q <= in_pin;
			in_s2_q <= in_s1_q;
			rp_s1_q <= reset_pin_n;
			rp_s2_q <= rp_s1_q;
			ext_s1_q <= ext_clock_pin;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			div_q <= '0;
		else if (int_tick)
			div_q <= '0;
		else
			div_q <= div_q + 1'b1;
	end
	assign int_tick = (div_q == DIV_W'(INT_DIV - 1));

	// ----------------------------------------------------------------
	// Operating mode
	// ----------------------------------------------------------------
	assign wake = rp_s2_q | in_on_q[0] | in_on_q[1];
	assign fault_term = (|overcurrent_fault) | (|overtemp_fault) |
		(|severe_short_fault) | undervoltage_fault |
		(overvoltage_fault & gcfg_q[G_OV_EN]);

	always_comb begin
		if (!wake)
			mode_d = M_SLEEP;
		else if (fault_term && failsafe_req)
			mode_d = M_FLT_FS;
		else if (fault_term)
			mode_d = M_FAULT;
		else if (failsafe_req)
			mode_d = M_FSAFE;
		else
			mode_d = M_NORMAL;
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			mode_q <= M_SLEEP;
		else
			mode_q <= mode_d;
	end

	always_comb begin
		case (mode_q)
			M_FSAFE, M_FLT_FS: fs_now = 1'b1;
			default: fs_now = 1'b0;
		endcase
	end
	// Only entry from outside fail-safe delatches; faults inside it do not
	assign fs_entry = (mode_d == M_FLT_FS || mode_d == M_FSAFE) &&
		!fs_now;

	// ----------------------------------------------------------------
	// APB slave: no wait states, read data sampled at setup
	// ----------------------------------------------------------------
	assign acc = psel & penable;
	assign wr = acc & pwrite & ~fs_now;
	assign rd = acc & ~pwrite & ~fs_now;
	assign clk_fail_act = ext_clock_fail & gcfg_q[G_CLKF_EN];

	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok = 1'b1;
		case (paddr)
			A_GCFG: rd_data[GCFG_W-1:0] = gcfg_q;
			A_GSTAT: begin
				rd_data[S_CLKF:0] = gstat_q;
				rd_data[S_FMODE] = (mode_q == M_FAULT || mode_q == M_FLT_FS);
				rd_data[S_FSAFE] = fs_now;
				rd_data[S_FSTAT] = fstat_n_q;
			end
			A_DUTY0: rd_data[ON_BIT:0] = duty_q[0];
			A_DUTY1: rd_data[ON_BIT:0] = duty_q[1];
			A_CCFG0: rd_data[DIR_DIS_BIT:0] = ccfg_q[0];
			A_CCFG1: rd_data[DIR_DIS_BIT:0] = ccfg_q[1];
			A_CUR0: rd_data[7:0] = cur_q[0];
			A_CUR1: rd_data[7:0] = cur_q[1];
			A_FLT0: rd_data[F_LATCH:0] = {latched_q[0], flt_q[0]};
			A_FLT1: rd_data[F_LATCH:0] = {latched_q[1], flt_q[1]};
			A_RETRY: rd_data = 32'h0000_0000;
			default: rd_ok = 1'b0;
		endcase
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			prdata_q <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			prdata_q <= (rd_ok && !fs_now) ? rd_data : 32'h0000_0000;
			pslverr_q <= ~rd_ok | fs_now;
		end
	end

	assign pready = acc;
	assign prdata = prdata_q;
	assign pslverr = pslverr_q;

	// Registers held at reset while in fail-safe
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			gcfg_q <= GCFG_RST;
			duty_q[0] <= DUTY_RST;
			duty_q[1] <= DUTY_RST;
			ccfg_q[0] <= CCFG_RST;
			ccfg_q[1] <= CCFG_RST;
			cur_q[0] <= CUR_RST;
			cur_q[1] <= CUR_RST;
		end else if (fs_now || fs_entry) begin
			gcfg_q <= GCFG_RST;
			duty_q[0] <= DUTY_RST;
			duty_q[1] <= DUTY_RST;
			ccfg_q[0] <= CCFG_RST;
			ccfg_q[1] <= CCFG_RST;
			cur_q[0] <= CUR_RST;
			cur_q[1] <= CUR_RST;
		end else if (wr) begin
			if (hit(paddr, A_GCFG))
				gcfg_q <= pwdata[GCFG_W-1:0] & GCFG_MASK;
			if (hit(paddr, A_DUTY0))
				duty_q[0] <= pwdata[ON_BIT:0];
			if (hit(paddr, A_DUTY1))
				duty_q[1] <= pwdata[ON_BIT:0];
			if (hit(paddr, A_CCFG0))
				ccfg_q[0] <= pwdata[DIR_DIS_BIT:0];
			if (hit(paddr, A_CCFG1))
				ccfg_q[1] <= pwdata[DIR_DIS_BIT:0];
			if (hit(paddr, A_CUR0))
				cur_q[0] <= pwdata[7:0] & CUR_MASK;
			if (hit(paddr, A_CUR1))
				cur_q[1] <= pwdata[7:0] & CUR_MASK;
		end
	end

	// Global sticky bits; set wins over the read clear
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			gstat_q <= '0;
		else begin
			if (rd && hit(paddr, A_GSTAT)) begin
				if (!undervoltage_fault)
					gstat_q[S_UV] <= 1'b0;
				if (!overvoltage_fault)
					gstat_q[S_OV] <= 1'b0;
				if (!ext_clock_fail)
					gstat_q[S_CLKF] <= 1'b0;
			end
			if (undervoltage_fault)
				gstat_q[S_UV] <= 1'b1;
			if (overvoltage_fault && gcfg_q[G_OV_EN])
				gstat_q[S_OV] <= 1'b1;
			if (clk_fail_act)
				gstat_q[S_CLKF] <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Per-channel supervision
	// ----------------------------------------------------------------
	for (genvar g = 0; g < 2; g++) begin : g_ch
		swfpc_pwm_if pif();
		logic fc, lf_cause, turn_on, delatch, rtry_en, expire, exhausted;
		logic rd_me, ch_off, direct;
		logic [FLT_W-1:0] cause, en_mask;

		assign rtry_en = cur_q[g][R_EN_BIT];
		assign fc = (in_on_q[g] & ~ccfg_q[g][DIR_DIS_BIT]) |
			duty_q[g][ON_BIT];
		assign lf_cause = overcurrent_fault[g] | severe_short_fault[g] |
			overtemp_fault[g] | undervoltage_fault;
		assign turn_on = fc & ~fc_prev_q[g];
		assign delatch = (turn_on & fc_arm_q[g]) | fs_entry |
			(wr & hit(paddr, A_RETRY) & pwdata[g] & rtry_en);
		assign expire = tripped_q[g] & ~latched_q[g] & rtry_en &
			(rtmr_q[g] == '0);
		assign exhausted = rcnt_q[g] == cur_q[g][R_LIM_W-1:0];
		assign rd_me = rd & hit(paddr, g == 0 ? A_FLT0 : A_FLT1);
		assign cause = {openload_off_fault[g], openload_on_fault[g],
			short_supply_fault[g], overtemp_fault[g],
			severe_short_fault[g], overcurrent_fault[g]};
		assign en_mask = {gcfg_q[G_OLOFF_EN], gcfg_q[G_OLON_EN],
			gcfg_q[G_OS_EN], 3'h7};

		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b)
				in_tmr_q[g] <= '0;
			else if (in_s2_q[g])
				in_tmr_q[g] <= TMR_W'(IN_TIMEOUT);
			else if (in_tmr_q[g] != '0)
				in_tmr_q[g] <= in_tmr_q[g] - 1'b1;
		end

		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b)
				in_on_q[g] <= 1'b0;
			else
				in_on_q[g] <= in_s2_q[g] | (in_tmr_q[g] != '0);
		end

		// 1-0-1 detector on fault-control
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b) begin
				fc_prev_q[g] <= 1'b0;
				fc_arm_q[g] <= 1'b0;
			end else begin
				fc_prev_q[g] <= fc;
				if (fc_prev_q[g] && !fc)
					fc_arm_q[g] <= 1'b1;
				else if (turn_on)
					fc_arm_q[g] <= 1'b0;
			end
		end

		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b)
				rtmr_q[g] <= '0;
			else if (!tripped_q[g] || expire)
				rtmr_q[g] <= RTY_W'(RETRY_CYC);
			else if (rtmr_q[g] != '0)
				rtmr_q[g] <= rtmr_q[g] - 1'b1;
		end

		// Counter survives fail-safe transitions
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b)
				rcnt_q[g] <= '0;
			else if (delatch && !fs_entry)
				rcnt_q[g] <= '0;
			else if (expire && !exhausted)
				rcnt_q[g] <= rcnt_q[g] + 1'b1;
		end

		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b) begin
				tripped_q[g] <= 1'b0;
				latched_q[g] <= 1'b0;
				seen_on_q[g] <= 1'b0;
			end else begin
				if (delatch)
					latched_q[g] <= 1'b0;
				else if (expire && exhausted && lf_cause)
					latched_q[g] <= 1'b1;
				if (lf_cause && !tripped_q[g])
					seen_on_q[g] <= 1'b0;
				else if ((expire && !(exhausted && lf_cause)) ||
					(turn_on && !latched_q[g]) || delatch)
					seen_on_q[g] <= 1'b1;
				if (lf_cause)
					tripped_q[g] <= 1'b1;
				else if ((expire && !exhausted) || turn_on || delatch)
					tripped_q[g] <= 1'b0;
			end
		end

		// Sticky channel bits: set wins over clear
		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b)
				flt_q[g] <= '0;
			else begin
				for (int b = 0; b < FLT_W; b++) begin
					if (cause[b] && en_mask[b])
						flt_q[g][b] <= 1'b1;
					else if (delatch && latched_q[g] && FLT_LATCHABLE[b])
						flt_q[g][b] <= 1'b0;
					else if (rd_me && !latched_q[g] &&
						(!FLT_LATCHABLE[b] || seen_on_q[g]))
						flt_q[g][b] <= 1'b0;
				end
			end
		end

		assign pif.enable = gcfg_q[G_PWM_EN0 + g] &
			~(clk_fail_act & ~cur_q[g][CLK_INT_BIT]);
		assign pif.clk_int = cur_q[g][CLK_INT_BIT];
		assign pif.prescale = cur_q[g][PRESC_BIT];
		assign pif.on = duty_q[g][ON_BIT];
		assign pif.duty = duty_q[g][DUTY_W-1:0];
		assign pif.delay = ccfg_q[g][DELAY_W-1:0];
		assign pif.ext_tick = ext_s2_q & ~ext_s3_q;
		assign pif.int_tick = int_tick;
		assign pwm_out[g] = pif.pwm_out;

		swfpc_pwm u_pwm (
			.clock(clock),
			.rst_b(rst_b),
			.bus(pif)
		);

		// Openload, short-to-supply and clock fail leave channel on
		assign ch_off = tripped_q[g] | latched_q[g] | undervoltage_fault |
			(overvoltage_fault & gcfg_q[G_OV_EN]) | ~wake;
		assign direct = in_s2_q[g] & ~ccfg_q[g][DIR_DIS_BIT];

		always_ff @(posedge clock or negedge rst_b) begin
			if (!rst_b)
				hs_on_q[g] <= 1'b0;
			else if (fs_now)
				hs_on_q[g] <= in_s2_q[g] & ~ch_off;
			else
				hs_on_q[g] <= (direct | pwm_out[g]) & ~ch_off;
		end

		assign ch_fault[g] = (|(cause & en_mask)) | latched_q[g];
	end

	// ----------------------------------------------------------------
	// Fault status pin: live, low until both channels delatched
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b)
			fstat_n_q <= 1'b1;
		else
			fstat_n_q <= ~((|ch_fault) | undervoltage_fault | clk_fail_act |
				(overvoltage_fault & gcfg_q[G_OV_EN]));
	end

	assign hs_on = hs_on_q;
	assign fault_status_n = fstat_n_q;
	assign mode = mode_q;
endmodule

`default_nettype wire

/* verif/swfpc_host.sv */
// Host model of the direct input pins.
// Assumes want comes from the bench on the system clock.
`timescale 1ns/1ns
`default_nettype none
module swfpc_host #(
	parameter int unsigned TOUT = 50
) (
	input wire logic clock,
	input wire logic [1:0] want,
	output logic [1:0] in_pin
);
	int unsigned cnt = 0;
	initial in_pin = 2'h0;
	// A released pin stays low past the timeout, so a rise delatches
	always @(posedge clock) begin
		if (|(in_pin & ~want)) cnt <= TOUT + 4;
		else if (cnt != 0) cnt <= cnt - 1;
		in_pin <= (cnt != 0) ? (in_pin & want) : want;
	end
endmodule
`default_nettype wire

/* verif/swfpc_chk.sv */
// Checker: fault, mode and bus relations at the top ports.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module swfpc_chk (
	input wire logic clock,
	input wire logic rst_b,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic reset_pin_n,
	input wire logic [1:0] overcurrent_fault,
	input wire logic undervoltage_fault,
	input wire logic overvoltage_fault,
	input wire logic [1:0] hs_on,
	input wire logic fault_status_n,
	input wire swfpc_pkg::swfpc_mode_t mode
);
	import swfpc_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	wire logic fs = mode == M_FSAFE || mode == M_FLT_FS;
	sequence s_setup; psel && !penable; endsequence
	sequence s_woke_oc; reset_pin_n && overcurrent_fault[0]; endsequence
	property p_fsb_live;
		mode != M_SLEEP && (|overcurrent_fault || undervoltage_fault)
		|=> !fault_status_n;
	endproperty
	property p_trip_off; $rose(overcurrent_fault[0]) |-> ##2 !hs_on[0];
	endproperty
	property p_uv_both; $rose(undervoltage_fault) |-> ##2 hs_on == 2'h0;
	endproperty
	property p_ov_both; $rose(overvoltage_fault) |-> ##2 hs_on == 2'h0;
	endproperty
	property p_fault_mode;
		s_woke_oc [*4] |-> mode == M_FAULT || mode == M_FLT_FS;
	endproperty
	property p_sleep_off; mode == M_SLEEP [*3] |-> hs_on == 2'h0;
	endproperty
	property p_fs_err; s_setup ##0 fs |=> pslverr; endproperty
	property p_err_zero; s_setup ##1 pslverr |-> prdata == 32'h0;
	endproperty
	a_fsb_live: assert property (p_fsb_live)
		else $error("status pin missed a fault");
	a_trip_off: assert property (p_trip_off)
		else $error("channel left on after trip");
	a_uv_both: assert property (p_uv_both)
		else $error("undervoltage left a channel on");
	a_ov_both: assert property (p_ov_both)
		else $error("overvoltage left a channel on");
	a_fault_mode: assert property (p_fault_mode)
		else $error("fault mode not entered");
	a_sleep_off: assert property (p_sleep_off)
		else $error("channel on while asleep");
	a_fs_err: assert property (p_fs_err)
		else $error("access accepted in fail-safe");
	a_err_zero: assert property (p_err_zero)
		else $error("refused read returned data");
endmodule
bind swfpc_top swfpc_chk chk (.clock, .rst_b, .psel, .penable, .prdata,
	.pslverr, .reset_pin_n, .overcurrent_fault, .undervoltage_fault,
	.overvoltage_fault, .hs_on, .fault_status_n, .mode);
`default_nettype wire

/* verif/swfpc_bench.sv */
// Bench for the switch control top: bus, faults, modes, modulator.
// Assumes the host pin model and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module swfpc_bench;
	import swfpc_pkg::*;
	localparam logic [31:0] T = 32'h1;
	localparam logic [31:0] F = 32'h0;
	logic clock = 1'b0, rst_b = 1'b0, fsr = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	swfpc_addr_t paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rdat;
	logic pready, pslverr, rerr, fault_status_n;
	logic [1:0] want = 2'h0, gv = 2'h0, in_pin, hs_on;
	logic [2:0] ecnt = 3'h0;
	logic [5:0] det = 6'h0;
	logic [3:0] aux = 4'h0;
	logic [7:0] r = 8'h5A;
	swfpc_mode_t mode;
	int err_total = 0, samples_checked = 0, k, t, n;
	swfpc_top #(.IN_TIMEOUT(50), .RETRY_CYC(20), .INT_DIV(4)) dut (
		.clock, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .in_pin, .reset_pin_n(~aux[3]),
		.ext_clock_pin(ecnt[2]), .overcurrent_fault(det[1:0]),
		.severe_short_fault(det[3:2]), .overtemp_fault(det[5:4]),
		.short_supply_fault({2{aux[0]}}),
		.openload_on_fault({2{aux[1]}}),
		.openload_off_fault({2{aux[1]}}), .undervoltage_fault(gv[0]),
		.overvoltage_fault(gv[1]), .ext_clock_fail(aux[2]),
		.failsafe_req(fsr), .hs_on, .fault_status_n, .mode);
	swfpc_host #(.TOUT(50)) host (.clock, .want, .in_pin);
	always #5 clock = ~clock;
	// External modulator clock, eight system cycles a period
	always @(posedge clock) ecnt <= ecnt + 3'h1;
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input swfpc_addr_t a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do @(posedge clock); while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask
	task automatic pwm_run(input logic [31:0] cur, input int per);
		int c;
		apb(1'b1, A_GCFG, 32'h28);
		apb(1'b1, A_CUR0, cur);
		apb(1'b1, A_DUTY0, {23'h0, 1'b1, n[7:0]});
		apb(1'b1, A_GCFG, 32'hA8);
		repeat (per / 2) @(posedge clock);
		c = 0;
		repeat (per) begin
			@(posedge clock);
			c += int'(hs_on[0]);
		end
		chk(c, (n + 1) * per / 256);
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#900000;
		err_total++;
		stop_test();
	end
	initial begin
		repeat (2) @(posedge clock);
		rst_b <= 1'b1;
		repeat (4) @(posedge clock);
		apb(1'b0, A_GCFG, F);
		chk(rdat, 32'h28);
		apb(1'b0, A_CUR0, F);
		chk(rdat, 32'h40);
		apb(1'b0, 8'h30, F);
		chk(rerr, T);
		// Corner duties first, then random; last run on the outside clock
		for (k = 0; k < 5; k++) begin
			n = k == 0 ? 0 : k == 1 ? 255 : int'(r);
			r = lfsr(r);
			pwm_run(k < 4 ? 32'h40 : 32'h80, k < 4 ? 1024 : 4096);
		end
		apb(1'b1, A_GCFG, 32'h28);
		apb(1'b1, A_CUR0, 32'h40);
		apb(1'b1, A_CCFG0, T);
		apb(1'b1, A_DUTY0, 32'h17F);
		apb(1'b1, A_GCFG, 32'hA8);
		t = 1;
		while (t < 300 && !(t > 6 && hs_on[0] === 1'b1)) begin
			@(posedge clock);
			t++;
		end
		chk(t >= 124 && t <= 140, T);
		apb(1'b1, A_GCFG, 32'h28);
		apb(1'b1, A_CCFG0, F);
		apb(1'b1, A_DUTY1, 32'h100);
		apb(1'b1, A_DUTY0, 32'h100);
		for (k = 0; k < 3; k++) begin
			det[2 * k] <= 1'b1;
			repeat (3) @(posedge clock);
			chk(hs_on, 32'h2);
			chk(fault_status_n, F);
			det[2 * k] <= 1'b0;
			repeat (3) @(posedge clock);
			apb(1'b0, A_FLT0, F);
			apb(1'b0, A_FLT0, F);
			chk(rdat[k], T);
			apb(1'b1, A_DUTY0, F);
			apb(1'b1, A_DUTY0, 32'h100);
			repeat (3) @(posedge clock);
			chk(hs_on[0], T);
			chk(fault_status_n, T);
			apb(1'b0, A_FLT0, F);
			chk(rdat[k], T);
			apb(1'b0, A_FLT0, F);
			chk(rdat[k], F);
		end
		for (k = 1; k >= 0; k--) begin
			gv[k] <= 1'b1;
			repeat (3) @(posedge clock);
			chk(hs_on, F);
			gv[k] <= 1'b0;
			repeat (3) @(posedge clock);
			apb(1'b0, A_GSTAT, F);
			chk(rdat[k], T);
		end
		apb(1'b1, A_CUR0, 32'h51);
		apb(1'b1, A_DUTY0, F);
		apb(1'b1, A_DUTY0, 32'h100);
		det[0] <= 1'b1;
		repeat (200) @(posedge clock);
		det[0] <= 1'b0;
		repeat (5) @(posedge clock);
		chk(fault_status_n, F);
		apb(1'b0, A_FLT0, F);
		apb(1'b0, A_FLT0, F);
		chk(rdat[6:0], 32'h41);
		apb(1'b1, A_RETRY, T);
		repeat (5) @(posedge clock);
		apb(1'b0, A_FLT0, F);
		chk(rdat[6:0], F);
		apb(1'b1, A_DUTY1, 32'h1FF);
		fsr <= 1'b1;
		want <= 2'h1;
		repeat (8) @(posedge clock);
		chk(hs_on, T);
		apb(1'b0, A_DUTY1, F);
		chk(rerr, T);
		chk(rdat, F);
		fsr <= 1'b0;
		want <= 2'h0;
		repeat (70) @(posedge clock);
		apb(1'b0, A_DUTY1, F);
		chk(rdat, F);
		// Non-latchable faults under default enables, then sleep
		apb(1'b1, A_DUTY0, 32'h100);
		aux <= 4'h7;
		repeat (3) @(posedge clock);
		chk(hs_on[0], T);
		chk(fault_status_n, F);
		apb(1'b0, A_FLT0, F);
		chk(rdat[5:3], F);
		apb(1'b0, A_GSTAT, F);
		chk(rdat[S_CLKF], T);
		aux <= 4'h8;
		repeat (4) @(posedge clock);
		chk(mode, M_SLEEP);
		chk(hs_on, F);
		stop_test();
	end
endmodule
`default_nettype wire
